// ---- eeprom_guard_dev.sv ----
// eeprom device end: status register, write latch, block and hardware protection
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// Function
// - protection needs low pin and armed bit
// - protection freezes guard and arm bits
// - hold suspends serial sequence, resumes after
// - master toggles hold only while clock low
// - hold tied high never pauses
// - status read-only when protected or latch clear
// - bit zero is active-high busy flag
// - busy accepts only status read
// - clear latch blocks every change
// - latch set only by command, cleared at reset
// - guard bits two and three, zero shipped
// - bits four to six not retained
// - bit seven arms; array never hardware-guarded
// - no arm clear while pin low
// - all bits read one while writing
// - master rereads status after busy clears
// - master may wait five ms instead
// - guard patterns select protected address ranges
// - guarded addresses read-only, others need latch
// - latch clears on disable or when a write starts
// - status write keeps only arm and guards
module eeprom_guard_dev #(
    parameter int WRITE_CYCLES = eeprom_guard_pkg::WRITE_CYCLES
) (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    // serial link
    eeprom_link_if.device    link,
    // array write port to the storage
    output logic             array_we_out,
    output logic [10:0]      array_addr_out,
    output logic [7:0]       array_data_out,
    // observed state
    output logic [7:0]       status_out,
    output logic             hw_protect_out
);
    typedef enum {IDLE, OPCODE, ADDR, DATA, STATUS_OUT, IGNORE} phase_type;

    logic [2:0]  sel_sync_reg, sck_sync_reg, mosi_sync_reg, hold_sync_reg, prot_sync_reg;
    logic        sel_n, sck_now, sck_prev_reg, mosi_now, hold_n, prot_n;
    logic        rise, fall;
    phase_type   phase_reg;
    logic [7:0]  shift_reg;
    logic [4:0]  bit_cnt_reg;
    logic [7:0]  opcode_reg;
    logic [15:0] addr_reg;
    logic        write_latch_reg;
    logic        hw_protect_arm_reg;
    logic        block_guard_lo_reg;
    logic        block_guard_hi_reg;
    logic [7:0]  pending_status_reg;
    logic        pending_status_reg_valid;
    logic        pending_array_reg;
    logic [10:0] pend_addr_reg;
    logic [7:0]  pend_data_reg;
    logic [31:0] busy_cnt_reg;
    logic        busy;
    logic        hw_protect;
    logic        guarded;
    logic [7:0]  status_now;
    logic [7:0]  out_shift_reg;
    logic        miso_reg, miso_oe_reg;
    logic        frame_end;

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for all link inputs; only stage 1 is read
    always_ff @(posedge clock_in) begin
        sel_sync_reg  <= {sel_sync_reg[1:0], link.select_n};
        sck_sync_reg  <= {sck_sync_reg[1:0], link.sck};
        mosi_sync_reg <= {mosi_sync_reg[1:0], link.mosi};
        hold_sync_reg <= {hold_sync_reg[1:0], link.hold_n};
        prot_sync_reg <= {prot_sync_reg[1:0], link.protect_n};
    end
    assign sel_n    = sel_sync_reg[1];
    assign sck_now  = sck_sync_reg[1];
    assign mosi_now = mosi_sync_reg[1];
    assign hold_n   = hold_sync_reg[1];
    assign prot_n   = prot_sync_reg[1];

    // edge detect on the synchronised clock
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_now;
        end
    end
    // clock edges are ignored while held; hold high never pauses
    assign rise = sck_now & ~sck_prev_reg & hold_n & ~sel_n;
    assign fall = ~sck_now & sck_prev_reg & hold_n & ~sel_n;

    ////////////////////////////////////////////////////////////////////////////
    // protection and status decode
    assign busy       = (busy_cnt_reg != 32'h0);
    assign hw_protect = ~prot_n & hw_protect_arm_reg;
    // status reads all ones while the internal write runs
    assign status_now = busy ? eeprom_guard_pkg::ALL_ONES :
                        {hw_protect_arm_reg, 3'b000, block_guard_hi_reg, block_guard_lo_reg,
                         write_latch_reg, 1'b0};
    // block guard ranges over the array address
    always_comb begin
        case ({block_guard_hi_reg, block_guard_lo_reg})
            2'b01:   guarded = (addr_reg[10:0] >= eeprom_guard_pkg::QUARTER_BASE);
            2'b10:   guarded = (addr_reg[10:0] >= eeprom_guard_pkg::HALF_BASE);
            2'b11:   guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    end
    assign frame_end = sel_n & (phase_reg != IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // serial sequence: opcode, address, data, status shift-out
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            phase_reg   <= IDLE;
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 5'h00;
            opcode_reg  <= 8'h00;
            addr_reg    <= 16'h0000;
        end else if (sel_n) begin
            phase_reg   <= IDLE;
            bit_cnt_reg <= 5'h00;
        end else begin
            if (phase_reg == IDLE) begin
                phase_reg <= OPCODE;
            end
            if (rise) begin                                     // counter frozen in hold
                shift_reg   <= {shift_reg[6:0], mosi_now};
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                if ((phase_reg == OPCODE || phase_reg == IDLE) && bit_cnt_reg == 5'd7) begin
                    opcode_reg  <= {shift_reg[6:0], mosi_now} & eeprom_guard_pkg::OP_MASK;
                    bit_cnt_reg <= 5'h00;
                    if (busy && (({shift_reg[6:0], mosi_now} & eeprom_guard_pkg::OP_MASK)
                                 != eeprom_guard_pkg::OP_STATUS_RD)) begin
                        phase_reg <= IGNORE;
                    end else begin
                        case ({shift_reg[6:0], mosi_now} & eeprom_guard_pkg::OP_MASK)
                            eeprom_guard_pkg::OP_STATUS_RD: phase_reg <= STATUS_OUT;
                            eeprom_guard_pkg::OP_STATUS_WR: phase_reg <= DATA;
                            eeprom_guard_pkg::OP_ARRAY_WR:  phase_reg <= ADDR;
                            default:                        phase_reg <= IGNORE;
                        endcase
                    end
                end else if (phase_reg == ADDR && bit_cnt_reg == 5'd15) begin
                    addr_reg    <= {addr_reg[7:0], shift_reg[6:0], mosi_now};
                    bit_cnt_reg <= 5'h00;
                    phase_reg   <= DATA;
                end else if (phase_reg == ADDR && bit_cnt_reg == 5'd7) begin
                    addr_reg[7:0] <= {shift_reg[6:0], mosi_now};
                end else if (phase_reg == DATA && bit_cnt_reg == 5'd7) begin
                    bit_cnt_reg <= 5'h00;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture status-write and array-write data at each completed data-phase byte
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            pending_status_reg       <= 8'h00;
            pending_status_reg_valid <= 1'b0;
            pending_array_reg        <= 1'b0;
            pend_addr_reg            <= 11'h000;
            pend_data_reg            <= 8'h00;
        end else if (phase_reg == IDLE) begin
            pending_status_reg_valid <= 1'b0;
            pending_array_reg        <= 1'b0;
        end else if (rise && phase_reg == DATA && bit_cnt_reg == 5'd7) begin
            if (opcode_reg == eeprom_guard_pkg::OP_STATUS_WR) begin
                // only arm and guard bits kept
                pending_status_reg       <= {shift_reg[6:0], mosi_now} & eeprom_guard_pkg::KEEP_MASK;
                pending_status_reg_valid <= 1'b1;
            end else begin
                pend_addr_reg     <= addr_reg[10:0];
                pend_data_reg     <= {shift_reg[6:0], mosi_now};
                pending_array_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write latch, guard and arm bits, internal write timer
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            write_latch_reg    <= 1'b0;
            hw_protect_arm_reg <= 1'b0;
            block_guard_lo_reg <= 1'b0;
            block_guard_hi_reg <= 1'b0;
            busy_cnt_reg       <= 32'h0;
            array_we_out       <= 1'b0;
            array_addr_out     <= 11'h000;
            array_data_out     <= 8'h00;
        end else begin
            array_we_out <= 1'b0;
            if (busy) begin
                busy_cnt_reg <= busy_cnt_reg - 32'h1;
            end
            if (frame_end && !busy) begin
                if (opcode_reg == eeprom_guard_pkg::OP_SET_LATCH) begin
                    write_latch_reg <= 1'b1;
                end else if (opcode_reg == eeprom_guard_pkg::OP_CLEAR_LATCH) begin
                    write_latch_reg <= 1'b0;
                end else if (pending_status_reg_valid && write_latch_reg && !hw_protect) begin
                    block_guard_lo_reg <= pending_status_reg[eeprom_guard_pkg::GUARD_LO_BIT];
                    block_guard_hi_reg <= pending_status_reg[eeprom_guard_pkg::GUARD_HI_BIT];
                    // arm may drop only while the pin is high
                    if (prot_n || pending_status_reg[eeprom_guard_pkg::ARM_BIT]) begin
                        hw_protect_arm_reg <= pending_status_reg[eeprom_guard_pkg::ARM_BIT];
                    end
                    busy_cnt_reg    <= 32'(WRITE_CYCLES);
                    write_latch_reg <= 1'b0;
                end else if (pending_array_reg && write_latch_reg && !guarded) begin
                    array_we_out    <= 1'b1;
                    array_addr_out  <= pend_addr_reg;
                    array_data_out  <= pend_data_reg;
                    busy_cnt_reg    <= 32'(WRITE_CYCLES);
                    write_latch_reg <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status shift-out on falling edges, tristate in hold or deselect
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            out_shift_reg <= 8'h00;
            miso_reg      <= 1'b0;
            miso_oe_reg   <= 1'b0;
        end else begin
            miso_oe_reg <= (phase_reg == STATUS_OUT) & ~sel_n & hold_n;
            if (phase_reg != STATUS_OUT) begin
                out_shift_reg <= status_now;
                miso_reg      <= status_now[7];
            end else if (fall && bit_cnt_reg == 5'd0) begin
                // first fall after the opcode launches a fresh snapshot, msb first
                miso_reg      <= status_now[7];
                out_shift_reg <= {status_now[6:0], 1'b0};
            end else if (fall) begin
                miso_reg      <= out_shift_reg[7];
                out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            end
        end
    end

    // registered observation outputs
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            status_out     <= eeprom_guard_pkg::STATUS_RESET;
            hw_protect_out <= 1'b0;
        end else begin
            status_out     <= status_now;
            hw_protect_out <= hw_protect;
        end
    end

    assign link.miso_out = miso_reg;
    assign link.miso_oe  = miso_oe_reg;
endmodule : eeprom_guard_dev

// ---- eeprom_guard_host.sv ----
// bus master end: apb-controlled spi sequencer with hold and protect pins
`timescale 1ns/10ps
module eeprom_guard_host (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // serial link
    eeprom_link_if.host      link
);
    typedef enum {H_IDLE, H_LOW, H_HIGH, H_DONE} host_state_type;

    host_state_type state_reg;
    logic [1:0]  miso_sync_reg;
    logic [15:0] tx_reg;
    logic [7:0]  rx_reg;
    logic [4:0]  bits_left_reg;
    logic [7:0]  div_reg;
    logic        busy_reg;
    logic        hold_req_reg, prot_n_reg;
    logic        sck_reg, sel_n_reg, mosi_reg, hold_n_reg;
    logic        tick;
    logic        apb_wr, apb_rd;

    assign apb_wr = psel_in & penable_in & pwrite_in;
    assign apb_rd = psel_in & penable_in & ~pwrite_in;
    assign tick   = (div_reg == 8'(eeprom_guard_pkg::SCK_HALF - 1));

    ////////////////////////////////////////////////////////////////////////////
    // miso sync
    always_ff @(posedge clock_in) begin
        miso_sync_reg <= {miso_sync_reg[0], link.miso_out};
    end

    // apb answer: zero wait, error on unmapped address
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0;
        end else begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in &
                           !(paddr_in inside {eeprom_guard_pkg::REG_CMD, eeprom_guard_pkg::REG_DATA,
                                              eeprom_guard_pkg::REG_STATUS, eeprom_guard_pkg::REG_PINS});
            case (paddr_in)
                eeprom_guard_pkg::REG_DATA:   prdata_out <= {24'h0, rx_reg};
                eeprom_guard_pkg::REG_STATUS: prdata_out <= {31'h0, busy_reg};
                eeprom_guard_pkg::REG_PINS:   prdata_out <= {30'h0, prot_n_reg, hold_req_reg};
                default:                      prdata_out <= 32'h0;
            endcase
        end
    end

    // pin control register: hold request bit 0, protect level bit 1
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            hold_req_reg <= 1'b0;
            prot_n_reg   <= 1'b1;
        end else if (apb_wr && pready_out && paddr_in == eeprom_guard_pkg::REG_PINS) begin
            hold_req_reg <= pwdata_in[0];
            prot_n_reg   <= pwdata_in[1];
        end
    end

    // hold changes only while the clock is low
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            hold_n_reg <= 1'b1;
        end else if (!sck_reg && !tick) begin                  // never on the cycle sck may rise
            hold_n_reg <= ~hold_req_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer: cmd reg {bit 8 = two bytes, [7:0] opcode}, data reg second byte
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            state_reg     <= H_IDLE;
            div_reg       <= 8'h00;
            tx_reg        <= 16'h0000;
            rx_reg        <= 8'h00;
            bits_left_reg <= 5'h00;
            busy_reg      <= 1'b0;
            sck_reg       <= 1'b0;
            sel_n_reg     <= 1'b1;
            mosi_reg      <= 1'b0;
        end else begin
            div_reg <= (tick || state_reg == H_IDLE) ? 8'h00 : div_reg + 8'h01;
            case (state_reg)
                H_IDLE: begin
                    if (apb_wr && pready_out && paddr_in == eeprom_guard_pkg::REG_DATA) begin
                        tx_reg[7:0] <= pwdata_in[7:0];
                    end else if (apb_wr && pready_out && paddr_in == eeprom_guard_pkg::REG_CMD) begin
                        tx_reg[15:8]  <= pwdata_in[7:0];
                        bits_left_reg <= pwdata_in[8] ? 5'd16 : 5'd8;
                        busy_reg      <= 1'b1;
                        sel_n_reg     <= 1'b0;
                        mosi_reg      <= pwdata_in[7];
                        state_reg     <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tick && hold_n_reg) begin
                        sck_reg   <= 1'b1;
                        state_reg <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        // sample late in the high phase: device bit and its sync delay have settled
                        rx_reg        <= {rx_reg[6:0], miso_sync_reg[1]};
                        sck_reg       <= 1'b0;
                        tx_reg        <= {tx_reg[14:0], 1'b0};
                        mosi_reg      <= tx_reg[14];
                        bits_left_reg <= bits_left_reg - 5'h01;
                        state_reg     <= (bits_left_reg == 5'h01) ? H_DONE : H_LOW;
                    end
                end
                H_DONE: begin
                    if (tick) begin
                        sel_n_reg <= 1'b1;
                        busy_reg  <= 1'b0;
                        state_reg <= H_IDLE;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end

    assign link.sck       = sck_reg;
    assign link.select_n  = sel_n_reg;
    assign link.mosi      = mosi_reg;
    assign link.hold_n    = hold_n_reg;
    assign link.protect_n = prot_n_reg;
endmodule : eeprom_guard_host

// ---- eeprom_guard_pkg.sv ----
// shared constants for the eeprom write-protect and status link
package eeprom_guard_pkg;
    // status register bit positions
    localparam int BUSY_BIT       = 0;
    localparam int LATCH_BIT      = 1;
    localparam int GUARD_LO_BIT   = 2;
    localparam int GUARD_HI_BIT   = 3;
    localparam int ARM_BIT        = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] ALL_ONES     = 8'hFF;
    localparam logic [7:0] KEEP_MASK    = 8'h8C;
    // opcodes, low nibble with don't-care bit 3 cleared
    localparam logic [7:0] OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_RD   = 8'h05;
    localparam logic [7:0] OP_STATUS_WR   = 8'h01;
    localparam logic [7:0] OP_ARRAY_WR    = 8'h02;
    localparam logic [7:0] OP_MASK        = 8'hF7;
    // array guard boundaries
    localparam logic [10:0] QUARTER_BASE = 11'h600;
    localparam logic [10:0] HALF_BASE    = 11'h400;
    // internal write time in device clocks (40 MHz)
    localparam int WRITE_TIME_US  = 4000;
    localparam int CLOCK_MHZ      = 40;
    localparam int WRITE_CYCLES   = WRITE_TIME_US * CLOCK_MHZ;
    // host wait after a write before reading status
    localparam int SETTLE_TIME_MS = 5;
    localparam int SETTLE_CYCLES  = SETTLE_TIME_MS * 1000 * CLOCK_MHZ;
    // link clock half period in device clocks (divider)
    localparam int SCK_HALF       = 4;
    // apb register offsets of the host controller
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_DATA   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PINS   = 8'h0C;
endpackage : eeprom_guard_pkg

// ---- eeprom_guard_props.sv ----
// concurrent checks on the serial link between the host and device ends
`timescale 1ns/10ps
module eeprom_guard_props (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // link signals
    input wire logic select_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe,
    input wire logic hold_n,
    input wire logic protect_n
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);
    // clock phase lengths set by the divider
    sequence high_run;
        sck [*3] ##1 !sck;
    endsequence
    sequence low_run;
        !sck [*3];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    // hold pin timing and its effect on the output
    a_hold_clock_low: assert property ($changed(hold_n) |-> !sck)
        else $error("hold moved while clock high");
    a_hold_edge_stable: assert property ($changed(sck) |-> $stable(hold_n))
        else $error("hold moved on a clock edge");
    a_held_out_off: assert property (!hold_n [*8] |-> !miso_oe)
        else $error("output driven during hold");
    a_hold_high_runs: assert property (hold_n && !select_n && !sck |-> ##[1:8] (sck || select_n || !hold_n))
        else $error("clock paused without hold");
    ////////////////////////////////////////////////////////////////////////////////
    // framing and clock shape
    a_idle_out_off: assert property (select_n [*8] |-> !miso_oe)
        else $error("output driven while deselected");
    a_sck_high_four: assert property ($rose(sck) |=> high_run)
        else $error("clock high phase not four cycles");
    a_sck_low_four: assert property ($fell(sck) && !select_n |=> low_run)
        else $error("clock low phase too short");
    a_frame_sck_low: assert property ($changed(select_n) |-> !sck && !$past(sck))
        else $error("select moved with clock high");
endmodule : eeprom_guard_props

// ---- eeprom_link_if.sv ----
// serial link between eeprom device end and bus master end
`timescale 1ns/10ps
interface eeprom_link_if;
    logic select_n;
    logic sck;
    logic mosi;
    logic miso_out;
    logic miso_oe;
    logic hold_n;
    logic protect_n;
    modport device (input select_n, input sck, input mosi, input hold_n, input protect_n,
                    output miso_out, output miso_oe);
    modport host (output select_n, output sck, output mosi, output hold_n, output protect_n,
                  input miso_out, input miso_oe);
endinterface : eeprom_link_if

// ---- tb.sv ----
// self-checking bench: host and device ends joined over the link
`timescale 1ns/10ps
module tb;
    typedef struct {logic [7:0] op, dat; logic pin; logic [7:0] exp, mask;} row_type;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        psel_in = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in = 1'b0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out, rd;
    logic        pready_out, pslverr_out, slv_err, array_we_out, hw_protect_out;
    logic [10:0] array_addr_out;
    logic [7:0]  array_data_out, status_out;
    int          err_total = 0;
    int          checks_done = 0;
    // opcode, data, protect level, expected status, compare mask
    row_type     rows [10] = '{'{8'h01, 8'h8C, 1, 8'h00, 8'hFF}, '{8'h06, 8'h00, 1, 8'h02, 8'hFF},
                               '{8'h04, 8'h00, 1, 8'h00, 8'hFF}, '{8'h06, 8'h00, 1, 8'h02, 8'hFF},
                               '{8'h01, 8'hFF, 1, 8'h8C, 8'hFF}, '{8'h06, 8'h00, 0, 8'h8E, 8'hFF},
                               '{8'h01, 8'h00, 0, 8'h8C, 8'hFD}, '{8'h06, 8'h00, 1, 8'h8E, 8'hFF},
                               '{8'h01, 8'h04, 1, 8'h04, 8'hFF}, '{8'h0E, 8'h00, 1, 8'h06, 8'hFF}};
    ////////////////////////////////////////////////////////////////////////////////
    // both ends, the link and the checker
    eeprom_link_if eeprom_link_if_i ();
    eeprom_guard_host eeprom_guard_host_i (.clock_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .link(eeprom_link_if_i));
    eeprom_guard_dev #(.WRITE_CYCLES(400)) eeprom_guard_dev_i (.clock_in, .rst_b_in, .link(eeprom_link_if_i),
        .array_we_out, .array_addr_out, .array_data_out, .status_out, .hw_protect_out);
    eeprom_guard_props eeprom_guard_props_i (.clock_in, .rst_b_in, .select_n(eeprom_link_if_i.select_n),
        .sck(eeprom_link_if_i.sck), .mosi(eeprom_link_if_i.mosi), .miso_out(eeprom_link_if_i.miso_out),
        .miso_oe(eeprom_link_if_i.miso_oe), .hold_n(eeprom_link_if_i.hold_n),
        .protect_n(eeprom_link_if_i.protect_n));
    // free-running clock
    always #12.5 clock_in = ~clock_in;
    ////////////////////////////////////////////////////////////////////////////////
    // verdict, compare and bus tasks
    task tally_and_finish;
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        rd = prdata_out;
        slv_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (n >= 50) begin
            err_total++;
            tally_and_finish();
        end
    endtask : apb
    // poll the host until its sequencer is free
    task host_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, eeprom_guard_pkg::REG_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 300);
        if (n >= 300) begin
            err_total++;
            tally_and_finish();
        end
    endtask : host_idle
    // send one instruction, then wait for the device to go idle
    task send(input logic [7:0] op, input logic [7:0] d, input logic two);
        int n;
        host_idle();
        apb(1'b1, eeprom_guard_pkg::REG_DATA, {24'h0, d});
        apb(1'b1, eeprom_guard_pkg::REG_CMD, {23'h0, two, op});
        host_idle();
        repeat (4) @(posedge clock_in);
        for (n = 0; status_out[0] !== 1'b0 && n < 1000; n++) @(posedge clock_in);
        if (n >= 1000) begin
            err_total++;
            tally_and_finish();
        end
    endtask : send
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int n;
        repeat (20) @(posedge clock_in);
        rst_b_in <= 1'b1;
        check(status_out, 8'h00);
        // table rows: instruction, then status read over the link
        foreach (rows[i]) begin
            apb(1'b1, eeprom_guard_pkg::REG_PINS, {30'h0, rows[i].pin, 1'b0});
            send(rows[i].op, rows[i].dat, rows[i].op == 8'h01);
            send(eeprom_guard_pkg::OP_STATUS_RD, 8'h00, 1'b1);
            apb(1'b0, eeprom_guard_pkg::REG_DATA, 32'h0);
            check(rd[7:0] & rows[i].mask, rows[i].exp);
            check(status_out & rows[i].mask, rows[i].exp);
            check(hw_protect_out, rows[i].exp[7] & ~rows[i].pin);
        end
        // instruction while a status write is still busy
        apb(1'b1, eeprom_guard_pkg::REG_DATA, 32'h0);
        apb(1'b1, eeprom_guard_pkg::REG_CMD, 32'h101);
        for (n = 0; status_out[0] !== 1'b1 && n < 500; n++) @(posedge clock_in);
        check(status_out, eeprom_guard_pkg::ALL_ONES);
        send(eeprom_guard_pkg::OP_SET_LATCH, 8'h00, 1'b0);
        check(status_out, 8'h00);
        // hold in mid read, then resume
        send(eeprom_guard_pkg::OP_SET_LATCH, 8'h00, 1'b0);
        apb(1'b1, eeprom_guard_pkg::REG_CMD, 32'h105);
        repeat (90) @(posedge clock_in);
        apb(1'b1, eeprom_guard_pkg::REG_PINS, 32'h3);
        repeat (40) @(posedge clock_in);
        check(eeprom_link_if_i.miso_oe, 1'b0);
        apb(1'b1, eeprom_guard_pkg::REG_PINS, 32'h2);
        host_idle();
        apb(1'b0, eeprom_guard_pkg::REG_DATA, 32'h0);
        check(rd[7:0], 8'h02);
        // unmapped register
        apb(1'b0, 8'h10, 32'h0);
        check(slv_err, 1'b1);
        // second reset clears the latch
        rst_b_in <= 1'b0;
        repeat (20) @(posedge clock_in);
        check(status_out, 8'h00);
        check(eeprom_link_if_i.select_n, 1'b1);
        tally_and_finish();
    end
endmodule : tb
